// ### dram_addr_split.sv
`timescale 1ns/1ps
module dram_addr_split #(
  parameter int ADDR_W = 24
) (
  input  logic                                    aclk,
  input  logic                                    aresetn,
  input  logic [1:0]                              asym_field,
  input  logic [1:0]                              global_type,
  input  logic [ADDR_W-1:0]                       host_addr,
  output logic [dram_cfg_pkg::ROW_MAX_W-1:0]      row_addr,
  output logic [dram_cfg_pkg::COL_MAX_W-1:0]      col_addr,
  output logic [3:0]                              row_width,
  output logic [3:0]                              col_width
);
  import dram_cfg_pkg::*;

  logic [3:0]           row_w;       // Selected row width
  logic [3:0]           col_w;       // Selected column width
  logic [ADDR_W-1:0]    shifted;     // Address with column bits dropped
  logic [COL_MAX_W-1:0] col_mask;    // Ones over the column bits
  logic [ROW_MAX_W-1:0] row_mask;    // Ones over the row bits
  logic [ROW_MAX_W-1:0] row_r;
  logic [COL_MAX_W-1:0] col_r;
  logic [3:0]           row_w_r;
  logic [3:0]           col_w_r;

  // Geometry from the field, falling back to the global type
  always_comb
  begin
    row_w = ASYM_ROW_W;
    col_w = ASYM_1M_COL;
    case (asym_field)
      ASYM_1M: col_w = ASYM_1M_COL;
      ASYM_2M: col_w = ASYM_2M_COL;
      ASYM_4M: col_w = ASYM_4M_COL;
      default:
      begin
        // Global setting decides
        case (global_type)
          2'h0:
          begin
            row_w = GLOB0_ROW_W;
            col_w = GLOB0_COL_W;
          end
          2'h1:
          begin
            row_w = GLOB1_ROW_W;
            col_w = GLOB1_COL_W;
          end
          2'h2:
          begin
            row_w = GLOB2_ROW_W;
            col_w = GLOB2_COL_W;
          end
          default:
          begin
            row_w = GLOB3_ROW_W;
            col_w = GLOB3_COL_W;
          end
        endcase
      end
    endcase
  end

  // Split of host address into row and column parts
  assign shifted  = host_addr >> col_w;
  assign col_mask = ~({COL_MAX_W{1'b1}} << col_w);
  assign row_mask = ~({ROW_MAX_W{1'b1}} << row_w);

  // Registered split, one cycle behind the inputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      row_r   <= '0;
      col_r   <= '0;
      row_w_r <= 4'h0;
      col_w_r <= 4'h0;
    end
    else
    begin
      row_r   <= shifted[ROW_MAX_W-1:0] & row_mask;
      col_r   <= host_addr[COL_MAX_W-1:0] & col_mask;
      row_w_r <= row_w;
      col_w_r <= col_w;
    end
  end

  assign row_addr  = row_r;
  assign col_addr  = col_r;
  assign row_width = row_w_r;
  assign col_width = col_w_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ASYM_1M: assert property (
    asym_field == ASYM_1M |=> col_width == 4'h8 && row_width == 4'hC)
    else $error("1M field gave wrong geometry");
  AST_ASYM_2M: assert property (
    asym_field == ASYM_2M |=> col_width == 4'h9 && row_width == 4'hC)
    else $error("2M field gave wrong geometry");
  AST_ASYM_4M: assert property (
    asym_field == ASYM_4M |=> col_width == 4'hA && row_width == 4'hC)
    else $error("4M field gave wrong geometry");
  AST_ASYM_GLOBAL: assert property (
    aresetn && asym_field == ASYM_GLOBAL && global_type == 2'h0
    |=> col_width == GLOB0_COL_W && row_width == GLOB0_ROW_W)
    else $error("Global type not used for field 00");
  AST_SPLIT: assert property (
    asym_field == ASYM_1M
    |=> col_addr == {2'h0, $past(host_addr[7:0])}
        && row_addr == $past(host_addr[19:8]))
    else $error("Row and column split wrong");

endmodule

// ### dram_bank_type_config.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Type bit: 0 fast page, 1 EDO
// - Bit n is bank n, reset zero
// - Flow bit forwards emulated writes to ISA
// - Address bit 20 mask emulation on at 0
// - Fast reset emulation on at 0
// - Keyboard port emulation on at 0
// - Strap high: both pins row strobes
// - Strap low, bit 1: strobe plus reset
// - Strap low, bit 0: bridge support
// - Type detection only while bit is 1
// - Two bits per bank, bank 7 top
// - Field 00 uses global type
// - Field 01: 12 rows, 8 columns
// - Field 10: 12 rows, 9 columns
// - Field 11: 12 rows, 10 columns
module dram_bank_type_config #(
  parameter int ADDR_W = 24
) (
  input  logic                                  aclk,
  input  logic                                  aresetn,
  input  logic [dram_cfg_pkg::AXI_ADDR_W-1:0]   s_axi_awaddr,
  input  logic                                  s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  logic [dram_cfg_pkg::AXI_DATA_W-1:0]   s_axi_wdata,
  input  logic [3:0]                            s_axi_wstrb,
  input  logic                                  s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  logic                                  s_axi_bready,
  input  logic [dram_cfg_pkg::AXI_ADDR_W-1:0]   s_axi_araddr,
  input  logic                                  s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [dram_cfg_pkg::AXI_DATA_W-1:0]   s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  logic                                  s_axi_rready,
  input  logic [2:0]                            bank_sel,
  input  logic [ADDR_W-1:0]                     host_addr,
  input  logic [1:0]                            global_type,
  output logic                                  bank_edo,
  output logic [dram_cfg_pkg::ROW_MAX_W-1:0]    row_addr,
  output logic [dram_cfg_pkg::COL_MAX_W-1:0]    col_addr,
  output logic [3:0]                            row_width,
  output logic [3:0]                            col_width,
  input  logic                                  io_wr_valid,
  input  logic [15:0]                           io_wr_port,
  output logic                                  io_claim,
  output logic                                  isa_forward,
  output logic                                  kbd_port_emul_en,
  output logic                                  fast_reset_emul_en,
  output logic                                  addr_bit20_mask_en,
  output logic                                  dram_detect_en,
  input  logic                                  pin_function_strap,
  input  logic                                  kbd_cpu_reset_request,
  output dram_cfg_pkg::pin_mode_t               pin_mode,
  output logic                                  row_strobe_bank_six_en,
  output logic                                  row_strobe_bank_five_en,
  output logic                                  p2p_bridge_en,
  output logic                                  cpu_reset_req
);
  import dram_cfg_pkg::*;

  logic [7:0]  type_r;             // Bank DRAM type select
  logic [7:0]  misc_r;             // Misc emulation / pin control
  logic [15:0] asym_r;             // Bank asymmetric organisation
  logic        aw_held_r;          // Write address waiting for data
  logic [11:0] aw_addr_r;
  logic        w_held_r;           // Write data waiting for address
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        strap_s1_r;         // Strap synchroniser stages
  logic        strap_r;
  logic        rst_req_s1_r;       // Reset request synchroniser stages
  logic        rst_req_r;
  logic        bank_edo_r;
  logic        io_claim_r;
  logic        isa_fwd_r;
  logic        cpu_rst_r;

  // Write channel decode
  wire         aw_fire  = s_axi_awvalid & s_axi_awready;
  wire         w_fire   = s_axi_wvalid & s_axi_wready;
  wire         do_write = (aw_held_r | aw_fire) & (w_held_r | w_fire);
  wire  [11:0] wa       = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire  [31:0] wd       = w_held_r ? w_data_r : s_axi_wdata;
  wire  [3:0]  ws       = w_held_r ? w_strb_r : s_axi_wstrb;
  wire         wa_type  = wa == ADDR_TYPE;
  wire         wa_misc  = wa == ADDR_MISC;
  wire         wa_asym  = wa == ADDR_ASYM;
  wire         wa_stat  = wa == ADDR_STATUS;
  wire         wa_ok    = wa_type | wa_misc | wa_asym | wa_stat;

  // Read channel decode
  wire         ar_fire  = s_axi_arvalid & s_axi_arready;
  wire         ra_type  = s_axi_araddr == ADDR_TYPE;
  wire         ra_misc  = s_axi_araddr == ADDR_MISC;
  wire         ra_asym  = s_axi_araddr == ADDR_ASYM;
  wire         ra_stat  = s_axi_araddr == ADDR_STATUS;
  wire         ra_ok    = ra_type | ra_misc | ra_asym | ra_stat;
  wire  [7:0]  status_w = {5'h00, strap_r, 2'(pin_mode)};
  wire  [31:0] rd_word  = ra_type ? {24'h000000, type_r} :
                          ra_misc ? {24'h000000, misc_r} :
                          ra_asym ? {16'h0000, asym_r} :
                          ra_stat ? {24'h000000, status_w} : 32'h00000000;

  // Bus handshakes, one write and one read under way at a time
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Write halves are held until both are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
    end
    else if (do_write)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_fire)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  // Write response, error for an unmapped address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wa_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // Configuration registers, byte lanes honoured
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      type_r <= TYPE_RST;
      misc_r <= MISC_RST;
      asym_r <= ASYM_RST;
    end
    else if (do_write)
    begin
      if (wa_type && ws[0])
        type_r <= wd[7:0];
      if (wa_misc && ws[0])
        misc_r <= wd[7:0] & MISC_RW_MASK;
      if (wa_asym && ws[0])
        asym_r[7:0] <= wd[7:0];
      if (wa_asym && ws[1])
        asym_r[15:8] <= wd[15:8];
    end
  end

  // Read data captured when the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= ra_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // Pin inputs pass two flops before use
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_s1_r <= 1'b0;
      strap_r    <= 1'b0;
      rst_req_s1_r <= 1'b0;
      rst_req_r    <= 1'b0;
    end
    else
    begin
      strap_s1_r <= pin_function_strap;
      strap_r    <= strap_s1_r;
      rst_req_s1_r <= kbd_cpu_reset_request;
      rst_req_r    <= rst_req_s1_r;
    end
  end

  // Shared pin use from strap and pin control bit
  assign pin_mode = strap_r ? PINS_TWO_RAS :
                    misc_r[MISC_PINCFG_BIT] ? PINS_RAS_RST :
                    PINS_P2P;
  assign row_strobe_bank_six_en  = pin_mode != PINS_P2P;
  assign row_strobe_bank_five_en = pin_mode == PINS_TWO_RAS;
  assign p2p_bridge_en           = pin_mode == PINS_P2P;

  // Emulation enables are active low in the control register; the detection enable is active high
  assign addr_bit20_mask_en = ~misc_r[MISC_A20_BIT];
  assign fast_reset_emul_en = ~misc_r[MISC_FRST_BIT];
  assign kbd_port_emul_en   = ~misc_r[MISC_KBD_BIT];
  assign dram_detect_en     = misc_r[MISC_DETECT_BIT];

  wire kbd_hit  = io_wr_valid &
                  (io_wr_port == KBD_DATA_PORT || io_wr_port == KBD_CMD_PORT);
  wire emul_hit = kbd_hit & kbd_port_emul_en;

  // Trapped writes, and their copy onto the ISA bus
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      io_claim_r <= 1'b0;
      isa_fwd_r  <= 1'b0;
      cpu_rst_r  <= 1'b0;
      bank_edo_r <= 1'b0;
    end
    else
    begin
      io_claim_r <= emul_hit;
      isa_fwd_r  <= io_wr_valid & (~emul_hit | misc_r[MISC_FLOW_BIT]);
      cpu_rst_r  <= rst_req_r & (pin_mode == PINS_RAS_RST);
      bank_edo_r <= type_r[bank_sel];
    end
  end

  assign io_claim      = io_claim_r;
  assign isa_forward   = isa_fwd_r;
  assign cpu_reset_req = cpu_rst_r;
  assign bank_edo      = bank_edo_r;

  // Per-bank organisation field
  wire [1:0] asym_field = asym_r[{bank_sel, 1'b0} +: 2];

  dram_addr_split #(
    .ADDR_W      (ADDR_W)
  ) u_split (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .asym_field  (asym_field),
    .global_type (global_type),
    .host_addr   (host_addr),
    .row_addr    (row_addr),
    .col_addr    (col_addr),
    .row_width   (row_width),
    .col_width   (col_width)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_both_in;
    do_write;
  endsequence
  sequence wr_answered;
    ##1 s_axi_bvalid;
  endsequence

  AST_WRITE_RESP: assert property (wr_both_in |-> wr_answered)
    else $error("Write response not one cycle after both halves");
  AST_BANK_EDO: assert property (
    ##1 bank_edo == $past(type_r[bank_sel]))
    else $error("Bank timing select does not follow type bit");
  AST_TYPE_WRITE: assert property (
    do_write && wa_type && ws[0] |=> type_r == $past(wd[7:0]))
    else $error("Type register write lost");
  AST_FLOW: assert property (
    emul_hit |=> isa_forward == $past(misc_r[MISC_FLOW_BIT]))
    else $error("Emulated write forwarding wrong");
  AST_A20: assert property (
    addr_bit20_mask_en != misc_r[MISC_A20_BIT])
    else $error("Mask emulation enable wrong");
  AST_FRST: assert property (
    fast_reset_emul_en != misc_r[MISC_FRST_BIT])
    else $error("Fast reset emulation enable wrong");
  AST_KBD_CLAIM: assert property (
    kbd_hit |=> io_claim == !$past(misc_r[MISC_KBD_BIT]))
    else $error("Keyboard port claim wrong");
  AST_STRAP_HIGH: assert property (
    strap_r |-> row_strobe_bank_six_en && row_strobe_bank_five_en)
    else $error("Strap high must give two row strobes");
  AST_PIN_RC: assert property (
    !strap_r && misc_r[MISC_PINCFG_BIT] && rst_req_r |=> cpu_reset_req)
    else $error("Reset request not passed");
  AST_PIN_P2P: assert property (
    !strap_r && !misc_r[MISC_PINCFG_BIT]
    |-> p2p_bridge_en && !row_strobe_bank_six_en ##1 !cpu_reset_req)
    else $error("Bridge mode wrong");
  AST_DETECT: assert property (
    dram_detect_en == misc_r[MISC_DETECT_BIT])
    else $error("Detection enable wrong");
  AST_FIELD: assert property (
    bank_sel == 3'h7 |-> asym_field == asym_r[15:14])
    else $error("Bank 7 field not in top bits");

endmodule

// ### dram_bank_type_config_tb.sv
`timescale 1ns/1ps
module dram_bank_type_config_tb;
  import dram_cfg_pkg::*;

  logic        aclk, aresetn;               // Clock and active-low reset
  logic [11:0] awaddr, araddr;              // Bus addresses
  logic [31:0] wdata, rdata, rnd;           // Bus data and random source
  logic [3:0]  wstrb, row_w, col_w;         // Strobes and geometry
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, bank_edo, io_valid;
  logic [1:0]  bresp, rresp, gtype;         // Responses and global type
  logic [2:0]  bank_sel;                    // Bank under access
  logic [23:0] host_addr;                   // Host address to split
  logic [11:0] row_addr;                    // Row portion
  logic [9:0]  col_addr;                    // Column portion
  logic [15:0] io_port, asym;               // Trap port, asymmetry value
  logic        claim, fwd, kbd_en, frst_en, a20_en, det_en, strap, kreq;
  logic        strobe6_en, strobe5_en, p2p_en, cpu_rst;
  logic [7:0]  v, t;                        // Misc and type values
  logic [3:0]  rw, cw;                      // Expected geometry
  pin_mode_t   pmode, m;                    // Seen and expected pin use
  int          bad_count, compares;         // Verdict counters
  logic [33:0] rd_q[$];                     // Expected read response
  logic [33:0] wr_q[$];                     // Expected write response
  logic [3:0]  grow [4] = '{GLOB0_ROW_W, GLOB1_ROW_W, GLOB2_ROW_W, GLOB3_ROW_W};
  logic [3:0]  gcol [4] = '{GLOB0_COL_W, GLOB1_COL_W, GLOB2_COL_W, GLOB3_COL_W};

  dram_bank_type_config i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bank_sel(bank_sel),
    .host_addr(host_addr), .global_type(gtype), .bank_edo(bank_edo),
    .row_addr(row_addr), .col_addr(col_addr), .row_width(row_w),
    .col_width(col_w), .io_wr_valid(io_valid), .io_wr_port(io_port),
    .io_claim(claim), .isa_forward(fwd), .kbd_port_emul_en(kbd_en),
    .fast_reset_emul_en(frst_en), .addr_bit20_mask_en(a20_en),
    .dram_detect_en(det_en), .pin_function_strap(strap),
    .kbd_cpu_reset_request(kreq), .pin_mode(pmode),
    .row_strobe_bank_six_en(strobe6_en),
    .row_strobe_bank_five_en(strobe5_en),
    .p2p_bridge_en(p2p_en), .cpu_reset_req(cpu_rst)
  );

  // Free-running 200 MHz clock
  always #2.5 aclk = ~aclk;

  // Next value of the random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Counts one comparison, reports a mismatch
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    compares++;
    if (seen !== want)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // Prints the verdict and ends the run
  task automatic print_verdict;
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Waits a number of rising edges
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Bus write; entered just after a rising edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wr_q.push_back({32'h0, er});
    // Each half is released at the edge that takes it
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1)
        awvalid <= 1'b0;
      if (!w_done && wready === 1'b1)
        wvalid <= 1'b0;
      aw_done = aw_done | (awready === 1'b1);
      w_done = w_done | (wready === 1'b1);
    end
    // Ready stays high so the next call never re-raises it in one step
    do @(posedge aclk); while (bvalid !== 1'b1);
  endtask

  // Bus read; the expected response is noted for the monitor
  task automatic axi_rd(input logic [11:0] a, input logic [33:0] want);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rd_q.push_back(want);
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
  endtask

  // One trapped I/O write and its one-cycle answer
  task automatic io_wr(input logic [15:0] p, input logic c, input logic f);
    io_port <= p;
    io_valid <= 1'b1;
    @(posedge aclk);
    io_valid <= 1'b0;
    @(posedge aclk);
    check(claim, c);
    check(fwd, f);
  endtask

  // Monitor: compares each bus answer at its handshake edge
  always @(posedge aclk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
      check({rresp, rdata}, rd_q.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1)
      check({32'h0, bresp}, wr_q.pop_front());
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, io_valid, io_port, strap, kreq} = '0;
    {bank_sel, host_addr, gtype} = '0;
    rnd = 32'hA1C1;
    tick(8);
    aresetn <= 1'b1;
    tick(2);
    // Values after reset
    check(kbd_en, 1'b1);
    check(frst_en, 1'b1);
    check(a20_en, 1'b1);
    check(det_en, 1'b0);
    check(p2p_en, 1'b1);
    axi_rd(ADDR_TYPE, {RESP_OKAY, 24'h0, TYPE_RST});
    axi_rd(ADDR_MISC, {RESP_OKAY, 24'h0, MISC_RST});
    axi_rd(ADDR_ASYM, {RESP_OKAY, 16'h0, ASYM_RST});
    // Type bits, one bank at a time
    rnd = lfsr(rnd);
    t = rnd[7:0];
    axi_wr(ADDR_TYPE, rnd, 4'hF, RESP_OKAY);
    axi_rd(ADDR_TYPE, {RESP_OKAY, 24'h0, t});
    for (int b = 0; b < 8; b++)
    begin
      bank_sel <= b[2:0];
      tick(2);
      check(bank_edo, t[b]);
    end
    // Misc controls with every pairing of flow and port emulation
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      v = {i[1], rnd[6:5], i[0], rnd[3:0]};
      axi_wr(ADDR_MISC, {rnd[31:8], v}, 4'h1, RESP_OKAY);
      axi_rd(ADDR_MISC, {RESP_OKAY, 24'h0, v & MISC_RW_MASK});
      check(a20_en, !v[6]);
      check(frst_en, !v[5]);
      check(kbd_en, !v[4]);
      check(det_en, v[0]);
      io_wr(KBD_DATA_PORT, !v[4], v[4] | v[7]);
      io_wr(KBD_CMD_PORT, !v[4], v[4] | v[7]);
      io_wr(16'h0070, 1'b0, 1'b1);
    end
    // Shared pin use for strap and control bit
    for (int s = 1; s >= 0; s--)
    begin
      for (int p = 0; p < 2; p++)
      begin
        axi_wr(ADDR_MISC, {28'h0, p[0], 3'h0}, 4'h1, RESP_OKAY);
        strap <= s[0];
        kreq <= 1'b1;
        tick(4);
        m = s[0] ? PINS_TWO_RAS : (p[0] ? PINS_RAS_RST : PINS_P2P);
        check(pmode, m);
        check(strobe6_en, m != PINS_P2P);
        check(strobe5_en, m == PINS_TWO_RAS);
        check(p2p_en, m == PINS_P2P);
        check(cpu_rst, m == PINS_RAS_RST);
        kreq <= 1'b0;
        axi_rd(ADDR_STATUS, {RESP_OKAY, 29'h0, s[0], m});
      end
    end
    // Read-only and unmapped places
    axi_wr(ADDR_STATUS, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    axi_wr(12'h004, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    axi_rd(12'h004, {RESP_SLVERR, 32'h0});
    axi_rd(ADDR_TYPE, {RESP_OKAY, 24'h0, t});
    // Every organisation code in every bank field
    for (int b = 0; b < 8; b++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        rnd = lfsr(rnd);
        asym = rnd[15:0];
        asym[2*b +: 2] = c[1:0];
        gtype <= rnd[17:16];
        bank_sel <= b[2:0];
        host_addr <= rnd[31:8];
        axi_wr(ADDR_ASYM, {16'h0, asym}, 4'h3, RESP_OKAY);
        tick(1);
        rw = (c == 0) ? grow[rnd[17:16]] : 4'hC;
        cw = (c == 0) ? gcol[rnd[17:16]] : 4'h7 + c[3:0];
        check(row_w, rw);
        check(col_w, cw);
        check(col_addr, rnd[17:8] & ((10'h1 << cw) - 10'h1));
        check(row_addr, (rnd[31:8] >> cw) & ((24'h1 << rw) - 24'h1));
        axi_rd(ADDR_ASYM, {RESP_OKAY, 16'h0, asym});
      end
    end
    // Low byte strobe leaves the upper fields alone
    axi_wr(ADDR_ASYM, 32'h0000_FFFF, 4'h1, RESP_OKAY);
    axi_rd(ADDR_ASYM, {RESP_OKAY, 16'h0, asym[15:8], 8'hFF});
    tick(4);
    print_verdict();
  end
endmodule

// ### dram_cfg_pkg.sv
package dram_cfg_pkg;

  // Bus geometry
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;

  // Register indexes, byte address is four times the index
  localparam logic [7:0] IDX_TYPE   = 8'h66;  // Bank DRAM type select
  localparam logic [7:0] IDX_MISC   = 8'h67;  // Misc emulation / pins
  localparam logic [7:0] IDX_ASYM   = 8'h68;  // Bank asymmetric organisation
  localparam logic [7:0] IDX_STATUS = 8'h6C;  // Live pin status, read only

  localparam logic [11:0] ADDR_TYPE   = {2'b00, IDX_TYPE, 2'b00};
  localparam logic [11:0] ADDR_MISC   = {2'b00, IDX_MISC, 2'b00};
  localparam logic [11:0] ADDR_ASYM   = {2'b00, IDX_ASYM, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};

  // Values after reset
  localparam logic [7:0]  TYPE_RST = 8'h00;
  localparam logic [7:0]  MISC_RST = 8'h00;
  localparam logic [15:0] ASYM_RST = 16'h0000;

  // Misc control field positions
  localparam int MISC_FLOW_BIT   = 7;
  localparam int MISC_A20_BIT    = 6;
  localparam int MISC_FRST_BIT   = 5;
  localparam int MISC_KBD_BIT    = 4;
  localparam int MISC_PINCFG_BIT = 3;
  localparam int MISC_DETECT_BIT = 0;
  localparam logic [7:0] MISC_RW_MASK = 8'hF9;  // Bits 2:1 read as zero

  // Emulated keyboard controller ports
  localparam logic [15:0] KBD_DATA_PORT = 16'h0060;
  localparam logic [15:0] KBD_CMD_PORT  = 16'h0064;

  // Asymmetry field codes and their geometry
  localparam logic [1:0] ASYM_GLOBAL = 2'h0;
  localparam logic [1:0] ASYM_1M     = 2'h1;
  localparam logic [1:0] ASYM_2M     = 2'h2;
  localparam logic [1:0] ASYM_4M     = 2'h3;
  localparam logic [3:0] ASYM_ROW_W  = 4'hC;
  localparam logic [3:0] ASYM_1M_COL = 4'h8;
  localparam logic [3:0] ASYM_2M_COL = 4'h9;
  localparam logic [3:0] ASYM_4M_COL = 4'hA;

  // Geometry taken from the global DRAM type setting
  localparam logic [3:0] GLOB0_ROW_W = 4'hA;
  localparam logic [3:0] GLOB0_COL_W = 4'h8;
  localparam logic [3:0] GLOB1_ROW_W = 4'hB;
  localparam logic [3:0] GLOB1_COL_W = 4'h9;
  localparam logic [3:0] GLOB2_ROW_W = 4'hC;
  localparam logic [3:0] GLOB2_COL_W = 4'hA;
  localparam logic [3:0] GLOB3_ROW_W = 4'hC;
  localparam logic [3:0] GLOB3_COL_W = 4'hA;

  localparam int ROW_MAX_W = 12;
  localparam int COL_MAX_W = 10;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Use of the two shared package pins
  typedef enum logic [1:0] {PINS_TWO_RAS, PINS_RAS_RST, PINS_P2P} pin_mode_t;

endpackage
